// [core/window_watchdog_reset.sv]
// Window watchdog with power-on and supply reset generation.
// Assumes all pin inputs are asynchronous; comparators for supply
// level and load current sit outside and deliver clean logic levels.

`timescale 1ns/10ps
`default_nettype none

module window_watchdog_reset #(
    parameter int SAMPLE_CYCLES = wdog_pkg::SAMPLE_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic trigger_input_i,
    input wire logic timing_select_bit_one_i,
    input wire logic timing_select_bit_two_i,
    input wire logic load_current_high_i,
    input wire logic supply_ok_i,
    output logic reset_output_n_o,
    output logic open_window_o
);

    localparam int DIV_W = $clog2(SAMPLE_CYCLES + 1);
    localparam int RR_W = $clog2(wdog_pkg::REACTION_CYCLES + 1);

    // The divider needs at least two clocks per sample tick
    if (SAMPLE_CYCLES < 2) begin : gen_bad_sample
        $error("SAMPLE_CYCLES must be at least 2");
    end

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;

    // Two flops per pin; only sync2_reg is read by logic
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
        end else begin
            sync1_reg <= {supply_ok_i, load_current_high_i,
                          timing_select_bit_two_i, timing_select_bit_one_i,
                          trigger_input_i};
            sync2_reg <= sync1_reg;
        end
    end

    logic trig_s;
    logic [1:0] mode_s;
    logic load_s;
    logic supply_s;
    logic slow;
    logic wd_off;

    assign trig_s = sync2_reg[0];
    assign mode_s = sync2_reg[2:1];
    assign load_s = sync2_reg[3];
    assign supply_s = sync2_reg[4];
    // Anything but all-low or all-high is taken as slow timing
    assign slow = (mode_s != wdog_pkg::MODE_FAST) &&
                  (mode_s != wdog_pkg::MODE_OFF);
    assign wd_off = (mode_s == wdog_pkg::MODE_OFF) || !load_s;

    // ----------------------------------------------------------------
    // Timebase divider and supply filter
    // ----------------------------------------------------------------
    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] div_next;
    logic half_reg;
    logic half_next;
    logic tick_reg;
    logic tick_next;
    logic [RR_W-1:0] low_reg;
    logic [RR_W-1:0] low_next;
    logic supply_fail;

    // Slow timing skips every other divider wrap, doubling the sample period and every window but not the supply reaction time
    always_comb begin
        div_next = div_reg + DIV_W'(1);
        half_next = half_reg;
        tick_next = 1'b0;
        if (div_reg == DIV_W'(SAMPLE_CYCLES - 1)) begin
            div_next = '0;
            half_next = slow ? !half_reg : 1'b0;
            tick_next = !slow || half_reg;
        end
        low_next = low_reg;
        if (supply_s) begin
            low_next = '0;
        end else if (low_reg != RR_W'(wdog_pkg::REACTION_CYCLES)) begin
            low_next = low_reg + RR_W'(1);
        end
    end

    // Short dips below the reaction time never reach the reset
    assign supply_fail =
        (low_reg == RR_W'(wdog_pkg::REACTION_CYCLES));

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_reg <= '0;
            half_reg <= 1'b0;
            tick_reg <= 1'b0;
            low_reg <= '0;
        end else begin
            div_reg <= div_next;
            half_reg <= half_next;
            tick_reg <= tick_next;
            low_reg <= low_next;
        end
    end

    // ----------------------------------------------------------------
    // Window sequencer
    // ----------------------------------------------------------------
    function automatic logic [wdog_pkg::WIN_W-1:0] win_len(
        input wdog_pkg::wd_state_t st
    );
        unique case (st)
            wdog_pkg::ST_RESET: win_len = wdog_pkg::RESET_DELAY_TICKS;
            wdog_pkg::ST_IGNORE: win_len = wdog_pkg::IGNORE_TICKS;
            wdog_pkg::ST_LONG_OPEN: win_len = wdog_pkg::LONG_OPEN_TICKS;
            wdog_pkg::ST_CLOSED: win_len = wdog_pkg::CLOSED_TICKS;
            wdog_pkg::ST_OPEN: win_len = wdog_pkg::OPEN_TICKS;
            default: win_len = wdog_pkg::OPEN_TICKS;
        endcase
    endfunction

    wdog_pkg::wd_state_t state_reg;
    wdog_pkg::wd_state_t state_next;
    logic [wdog_pkg::WIN_W-1:0] win_reg;
    logic [wdog_pkg::WIN_W-1:0] win_next;
    logic [3:0] hist_reg;
    logic [3:0] hist_next;
    logic rst_n_reg;
    logic rst_n_next;
    logic open_reg;
    logic open_next;
    logic [3:0] hist_shift;
    logic trig_valid;
    logic last;

    // Falling edge seen as H,H,L,L over four samples
    assign hist_shift = {hist_reg[2:0], trig_s};
    assign trig_valid = (hist_shift == wdog_pkg::TRIG_PATTERN);
    assign last = (win_reg == win_len(state_reg) - wdog_pkg::WIN_W'(1));

    always_comb begin
        state_next = state_reg;
        win_next = win_reg;
        hist_next = hist_reg;
        if (supply_fail) begin
            state_next = wdog_pkg::ST_RESET;
            win_next = '0;
            hist_next = 4'h0;
        end else if (state_reg != wdog_pkg::ST_RESET && wd_off) begin
            state_next = wdog_pkg::ST_DISABLED;
            win_next = '0;
            hist_next = 4'h0;
        end else if (state_reg == wdog_pkg::ST_DISABLED) begin
            state_next = wdog_pkg::ST_IGNORE;
            win_next = '0;
        end else if (tick_reg) begin
            hist_next = hist_shift;
            win_next = win_reg + wdog_pkg::WIN_W'(1);
            unique case (state_reg)
                wdog_pkg::ST_RESET: begin
                    hist_next = 4'h0;
                    if (last) begin
                        state_next = wdog_pkg::ST_IGNORE;
                        win_next = '0;
                    end
                end
                wdog_pkg::ST_IGNORE: begin
                    hist_next = 4'h0;
                    if (last) begin
                        state_next = wdog_pkg::ST_LONG_OPEN;
                        win_next = '0;
                    end
                end
                wdog_pkg::ST_LONG_OPEN, wdog_pkg::ST_OPEN: begin
                    if (trig_valid) begin
                        state_next = wdog_pkg::ST_CLOSED;
                        win_next = '0;
                    end else if (last) begin
                        state_next = wdog_pkg::ST_RESET;
                        win_next = '0;
                    end
                end
                wdog_pkg::ST_CLOSED: begin
                    // The sample on the closing tick already counts as open
                    if (last) begin
                        state_next = trig_valid ? wdog_pkg::ST_CLOSED
                                                : wdog_pkg::ST_OPEN;
                        win_next = '0;
                    end else if (trig_valid) begin
                        state_next = wdog_pkg::ST_RESET;
                        win_next = '0;
                    end
                end
                default: begin
                    state_next = wdog_pkg::ST_RESET;
                    win_next = '0;
                end
            endcase
        end
        rst_n_next = (state_next != wdog_pkg::ST_RESET);
        open_next = (state_next == wdog_pkg::ST_OPEN) ||
                    (state_next == wdog_pkg::ST_LONG_OPEN);
    end

    // Reset output low from the asynchronous reset onward
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= wdog_pkg::ST_RESET;
            win_reg <= '0;
            hist_reg <= 4'h0;
            rst_n_reg <= 1'b0;
            open_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            win_reg <= win_next;
            hist_reg <= hist_next;
            rst_n_reg <= rst_n_next;
            open_reg <= open_next;
        end
    end

    assign reset_output_n_o = rst_n_reg;
    assign open_window_o = open_reg;

endmodule // window_watchdog_reset

`default_nettype wire

// [core/wdog_pkg.sv]
// Constants for the window watchdog with reset generation.
// Assumes a 40 MHz core clock; all windows count sample-period ticks.
//
// Notes on behaviour
// - Divided clock timebase; two mode pins select timing; both high disable.
// - Mode pins both low select fast timing, the typical figures.
// - After power-on, reset output stays low for the reset delay, 16 ms.
// - Reset release starts a 32 ms ignore window; trigger is disregarded.
// - After the ignore window comes a long open window of four open windows.
// - A valid trigger in an open window starts a closed window at once.
// - A valid trigger inside a closed window is a pretrigger and causes reset.
// - Closed window expiry starts an open window of at most 32 ms.
// - An open window expiring without valid trigger causes reset.
// - Only a falling edge on the trigger input counts as a trigger.
// - Trigger sampled every 0.5 ms; valid after two high, two low samples.
// - Trigger whose fourth sample lands in the open window is valid.
// - Watchdog disabled by low load current keeps the reset output high.
// - Re-activation by load current restarts with ignore, long open window.
// - First valid trigger ends the long open window; normal windows follow.
// - Supply below threshold longer than reaction time drives reset low.

package wdog_pkg;

    // ----------------------------------------------------------------
    // Clock and timebase
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int SAMPLE_PERIOD_US = 500;
    localparam int SAMPLE_CYCLES =
        (SAMPLE_PERIOD_US * 1000000) / CLK_PERIOD_PS;
    localparam int REACTION_TIME_NS = 4000;
    localparam int REACTION_CYCLES =
        (REACTION_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ----------------------------------------------------------------
    // Window lengths in fast-timing ms, and in sample ticks
    // ----------------------------------------------------------------
    localparam int RESET_DELAY_MS = 16;
    localparam int IGNORE_WINDOW_MS = 32;
    localparam int OPEN_WINDOW_MS = 32;
    localparam int CLOSED_WINDOW_MS = 32;
    localparam int LONG_OPEN_FACTOR = 4;
    localparam int WIN_W = 9;
    localparam logic [WIN_W-1:0] RESET_DELAY_TICKS =
        WIN_W'(RESET_DELAY_MS * 1000 / SAMPLE_PERIOD_US);
    localparam logic [WIN_W-1:0] IGNORE_TICKS =
        WIN_W'(IGNORE_WINDOW_MS * 1000 / SAMPLE_PERIOD_US);
    localparam logic [WIN_W-1:0] OPEN_TICKS =
        WIN_W'(OPEN_WINDOW_MS * 1000 / SAMPLE_PERIOD_US);
    localparam logic [WIN_W-1:0] CLOSED_TICKS =
        WIN_W'(CLOSED_WINDOW_MS * 1000 / SAMPLE_PERIOD_US);
    localparam logic [WIN_W-1:0] LONG_OPEN_TICKS =
        WIN_W'(LONG_OPEN_FACTOR * OPEN_WINDOW_MS * 1000 / SAMPLE_PERIOD_US);

    // ----------------------------------------------------------------
    // Mode pin codes and trigger pattern
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_FAST = 2'h0;
    localparam logic [1:0] MODE_OFF = 2'h3;
    localparam logic [3:0] TRIG_PATTERN = 4'hc; // Oldest first: H H L L

    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_IGNORE = 3'b001,
        ST_LONG_OPEN = 3'b010,
        ST_CLOSED = 3'b011,
        ST_OPEN = 3'b100,
        ST_DISABLED = 3'b101
    } wd_state_t;

endpackage

// [tb/wdog_port_chk.sv]
// Port checker for the window watchdog.
// Assumes a bind onto window_watchdog_reset from the bench.
`timescale 1ns/10ps
`default_nettype none
module wdog_port_chk #(
    parameter int SAMPLE_CYCLES = 4
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic trigger_input_i,
    input wire logic timing_select_bit_one_i,
    input wire logic timing_select_bit_two_i,
    input wire logic load_current_high_i,
    input wire logic supply_ok_i,
    input wire logic reset_output_n_o,
    input wire logic open_window_o
);
    localparam int S = SAMPLE_CYCLES;
    localparam int DIP_N = wdog_pkg::REACTION_CYCLES + 2;
    logic [15:0] lo_reg, lo_next, hi_reg, hi_next;
    logic [15:0] op_reg, op_next, dip_reg, dip_next;
    // ----------------------------------------
    // Run lengths; 16 bits outlast any window at the bench's 4-clock tick
    // ----------------------------------------
    always_comb begin
        lo_next = reset_output_n_o ? 16'h0 : lo_reg + 16'h1;
        hi_next = reset_output_n_o ? hi_reg + 16'h1 : 16'h0;
        op_next = open_window_o ? op_reg + 16'h1 : 16'h0;
        dip_next = supply_ok_i ? 16'h0 : dip_reg + 16'h1;
    end
    // Registers only
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {lo_reg, hi_reg, op_reg, dip_reg} <= 64'h0;
        end else begin
            {lo_reg, hi_reg, op_reg, dip_reg} <=
                {lo_next, hi_next, op_next, dip_next};
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    chk_reset_no_open: assert property (
        !reset_output_n_o |-> !open_window_o) else $error("open in reset");
    chk_delay_len: assert property (
        $rose(reset_output_n_o) |-> lo_reg >= 16'(31 * S))
        else $error("reset delay too short");
    chk_ignore_len: assert property (
        $rose(open_window_o) |-> hi_reg >= 16'(63 * S))
        else $error("ignore window too short");
    chk_open_max: assert property (
        op_reg <= 16'(514 * S + 8)) else $error("open window too long");
    chk_close_cause: assert property (
        $fell(open_window_o) && reset_output_n_o && load_current_high_i
        && supply_ok_i && !(timing_select_bit_one_i && timing_select_bit_two_i)
        |-> !$past(trigger_input_i, 3)) else $error("close without trigger");
    chk_load_off: assert property (
        (!load_current_high_i && supply_ok_i && reset_output_n_o)[*6]
        |=> reset_output_n_o && !open_window_o) else $error("disabled moved");
    chk_mode_off: assert property (
        (timing_select_bit_one_i && timing_select_bit_two_i
        && supply_ok_i && reset_output_n_o)[*6] |=> reset_output_n_o)
        else $error("mode off yet reset");
    chk_supply_dip: assert property (
        dip_reg == 16'(DIP_N) |-> ##[0:4] !reset_output_n_o)
        else $error("supply dip gave no reset");
    cov_release: cover property ($rose(reset_output_n_o));
    cov_trigger: cover property ($fell(open_window_o) && reset_output_n_o);
    cov_expire: cover property ($fell(reset_output_n_o) && $past(open_window_o));
endmodule // wdog_port_chk
`default_nettype wire

// [tb/mcu_model.sv]
// Controller model that pulls the trigger pin low on command.
// Assumes the bench commands it between clock edges.
`timescale 1ns/10ps
`default_nettype none
module mcu_model (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic fire_i,
    input wire logic [7:0] low_len_i,
    output logic trig_o
);
    logic [7:0] low_reg = 8'h0;
    // Low phase length in clocks; a short one is a glitch
    always @(posedge core_clk_i) begin
        if (fire_i) begin
            low_reg <= low_len_i;
        end else if (low_reg != 8'h0) begin
            low_reg <= low_reg - 8'h1;
        end
    end
    // Held in reset the pin floats and the pull-down wins
    assign trig_o = reset_n_i & (low_reg == 8'h0);
endmodule // mcu_model
`default_nettype wire

// [tb/window_watchdog_reset_test.sv]
// Self-checking bench for the window watchdog.
// Assumes the package is compiled first; the tick is cut to 4 clocks.
`timescale 1ns/10ps
`default_nettype none
module window_watchdog_reset_test;
    localparam int S = 4;
    localparam int DLY = int'(wdog_pkg::RESET_DELAY_TICKS) * S;
    localparam int IGN = int'(wdog_pkg::IGNORE_TICKS) * S;
    localparam int LNG = int'(wdog_pkg::LONG_OPEN_TICKS) * S;
    localparam int CLS = int'(wdog_pkg::CLOSED_TICKS) * S;
    localparam int OPN = int'(wdog_pkg::OPEN_TICKS) * S;
    localparam int T = 2 * S + 4; // Sync and divider slack
    logic core_clk_i = 1'h0;
    logic rst_n = 1'h0;
    logic sel_one = 1'h0;
    logic sel_two = 1'h0;
    logic load_high = 1'h1;
    logic supply_ok = 1'h1;
    logic fire = 1'h0;
    logic [7:0] low_len = 8'hc;
    wire logic trig, reset_n, open_w;
    int miscompares = 0;
    int cmp_count = 0;
    int n;
    always #12.5 core_clk_i = ~core_clk_i;
    mcu_model mcu_model_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n),
        .fire_i(fire), .low_len_i(low_len), .trig_o(trig));
    window_watchdog_reset #(.SAMPLE_CYCLES(S)) window_watchdog_reset_i (
        .core_clk_i(core_clk_i), .rstn_i(rst_n), .trigger_input_i(trig),
        .timing_select_bit_one_i(sel_one), .timing_select_bit_two_i(sel_two),
        .load_current_high_i(load_high), .supply_ok_i(supply_ok),
        .reset_output_n_o(reset_n), .open_window_o(open_w));
    task automatic check_bit(input string w, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", w, e, g);
        end
    endtask
    task automatic check_span(input string w, input int lo, hi, g);
        cmp_count++;
        if (g < lo || g > hi) begin
            miscompares++;
            $display("wrong value %s expected %0d..%0d seen %0d",
                     w, lo, hi, g);
        end
    endtask
    // Bounded wait so a stuck output cannot hang the run
    task automatic wait_for(input bit on_open, input logic lvl, output int c);
        c = 0;
        while (((on_open ? open_w : reset_n) !== lvl) && c < 6000) begin
            @(negedge core_clk_i);
            c++;
        end
    endtask
    task automatic pulse(input logic [7:0] len);
        low_len = len;
        fire = 1'h1;
        @(negedge core_clk_i);
        fire = 1'h0;
    endtask
    task automatic do_reset();
        rst_n = 1'h0;
        repeat (4) @(negedge core_clk_i);
        rst_n = 1'h1;
    endtask
    task automatic t_por();
        do_reset();
        wait_for(0, 1'h1, n);
        check_span("delay", DLY - T, DLY + T, n);
        wait_for(1, 1'h1, n);
        check_span("ignore", IGN - T, IGN + T, n);
        wait_for(0, 1'h0, n);
        check_span("long open", LNG - T, LNG + T, n);
        wait_for(0, 1'h1, n);
        check_span("delay again", DLY - T, DLY + T, n);
        $display("test por done");
    endtask
    task automatic t_trig();
        wait_for(1, 1'h1, n);
        // History restarts empty; let two high samples land first
        repeat (3 * S) @(negedge core_clk_i);
        pulse(8'hc);
        wait_for(1, 1'h0, n);
        check_span("sync close", 1, 3 * S + 6, n);
        wait_for(1, 1'h1, n);
        check_span("closed", CLS - T, CLS + T, n);
        repeat (OPN / 2) @(negedge core_clk_i);
        pulse(8'hc);
        wait_for(1, 1'h0, n);
        check_span("period close", 1, 3 * S + 6, n);
        wait_for(1, 1'h1, n);
        pulse(8'h4);
        repeat (4 * S) @(negedge core_clk_i);
        check_bit("glitch", 1'h1, open_w);
        pulse(8'hc);
        wait_for(1, 1'h0, n);
        repeat (CLS / 2) @(negedge core_clk_i);
        pulse(8'hc);
        wait_for(0, 1'h0, n);
        check_span("pretrigger", 1, 3 * S + 6, n);
        wait_for(0, 1'h1, n);
        $display("test trig done");
    endtask
    task automatic t_disable();
        load_high = 1'h0;
        repeat (LNG + OPN) @(negedge core_clk_i);
        check_bit("load off", 1'h1, reset_n);
        load_high = 1'h1;
        wait_for(1, 1'h1, n);
        check_span("reenable", IGN - T, IGN + T, n);
        {sel_one, sel_two} = 2'h3;
        repeat (LNG + OPN) @(negedge core_clk_i);
        check_bit("mode off", 1'h1, reset_n);
        check_bit("mode off open", 1'h0, open_w);
        {sel_one, sel_two} = 2'h0;
        wait_for(1, 1'h1, n);
        check_span("mode on", IGN - T, IGN + T, n);
        $display("test disable done");
    endtask
    task automatic t_supply();
        supply_ok = 1'h0;
        repeat (100) @(negedge core_clk_i);
        supply_ok = 1'h1;
        check_bit("short dip", 1'h1, reset_n);
        @(negedge core_clk_i);
        supply_ok = 1'h0;
        repeat (200) @(negedge core_clk_i);
        check_bit("long dip", 1'h0, reset_n);
        supply_ok = 1'h1;
        wait_for(0, 1'h1, n);
        check_span("dip delay", DLY - T, DLY + T, n);
        $display("test supply done");
    endtask
    task automatic t_slow();
        sel_one = 1'h1;
        do_reset();
        wait_for(0, 1'h1, n);
        check_span("slow delay", 2 * DLY - T, 2 * DLY + 2 * T, n);
        wait_for(1, 1'h1, n);
        check_span("slow ignore", 2 * IGN - T, 2 * IGN + 2 * T, n);
        $display("test slow done");
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        t_por();
        t_trig();
        t_disable();
        t_supply();
        t_slow();
        close_out();
    end
    // The tests need about 7100 clocks; allow well over twice that
    initial begin
        #(30000 * 25);
        miscompares++;
        close_out();
    end
endmodule // window_watchdog_reset_test
bind window_watchdog_reset wdog_port_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES))
    wdog_port_chk_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .trigger_input_i(trigger_input_i),
    .timing_select_bit_one_i(timing_select_bit_one_i),
    .timing_select_bit_two_i(timing_select_bit_two_i),
    .load_current_high_i(load_current_high_i), .supply_ok_i(supply_ok_i),
    .reset_output_n_o(reset_output_n_o), .open_window_o(open_window_o));
`default_nettype wire
